// [rtl/txpg_pkg.sv]
// txpg_pkg: constants for the transmit power gear controller
// assumes a 200 MHz core clock; all parameter bytes sit on an 8-bit address map
package txpg_pkg;

    // clock and time base
    localparam int unsigned CLK_PERIOD_PS  = 5000;
    localparam int unsigned GUARD_TICK_PS  = 50000;          // one period of 20 MHz
    localparam int unsigned GUARD_OFS_NS   = 51000;          // fixed guard offset, 51 us
    localparam int unsigned MEAS_UNIT_NS   = 1000;           // measure interval unit, 1 us
    localparam int unsigned GUARD_TICK_CYC = GUARD_TICK_PS / CLK_PERIOD_PS;
    localparam int unsigned GUARD_OFS_CYC  = (GUARD_OFS_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned MEAS_UNIT_CYC  = (MEAS_UNIT_NS * 1000) / CLK_PERIOD_PS;

    // table geometry
    localparam int unsigned GEAR_MAX       = 15;

    // byte offsets
    localparam logic [7:0] ADDR_CONTROL    = 8'h59;
    localparam logic [7:0] ADDR_INTERVAL_L = 8'h5D;
    localparam logic [7:0] ADDR_INTERVAL_H = 8'h5E;
    localparam logic [7:0] ADDR_THR_FIRST  = 8'h5F;
    localparam logic [7:0] ADDR_THR_LAST   = 8'h7C;
    localparam logic [7:0] ADDR_SHIFT      = 8'h80;
    localparam logic [7:0] ADDR_GEAR_COUNT = 8'h81;
    localparam logic [7:0] ADDR_PWR_FIRST  = 8'h82;
    localparam logic [7:0] ADDR_PWR_LAST   = 8'h90;
    localparam logic [7:0] ADDR_GUARD_L    = 8'h95;
    localparam logic [7:0] ADDR_GUARD_H    = 8'h96;
    localparam logic [7:0] ADDR_STATUS     = 8'h97;
    localparam logic [7:0] ADDR_LOW_THR_L  = 8'h98;
    localparam logic [7:0] ADDR_LOW_THR_H  = 8'h99;

    // control byte fields
    localparam int unsigned CTL_ENABLE_BIT = 0;
    localparam int unsigned CTL_STEP_LSB   = 1;
    localparam int unsigned CTL_START_LSB  = 4;

    // reset values
    localparam logic [7:0]  RST_CONTROL    = 8'h03;
    localparam logic [7:0]  RST_GEAR_COUNT = 8'h01;
    localparam logic [7:0]  RST_POWER      = 8'h00;
    localparam logic [15:0] RST_THRESHOLD  = 16'hFFFF;
    localparam logic [3:0]  RST_SHIFT      = 4'h2;
    localparam logic [15:0] RST_GUARD      = 16'h07D0;
    localparam logic [15:0] RST_INTERVAL   = 16'h0001;

    typedef enum logic [1:0] {
        TXPG_OFF,
        TXPG_GUARD,
        TXPG_INTERVAL,
        TXPG_MEASURE
    } txpg_state_t;

endpackage

// [rtl/txpg_ctrl.sv]
// txpg_ctrl: autonomous transmit power gear regulator with its parameter bytes
// assumes field_on_in, gain level and its valid come from logic on clk_in
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps

// How it works
// - up to fifteen gears, one power step each
// - gear zero strongest, highest gear weakest
// - regulates alone once enabled, no host
// - samples gain every configured measure interval
// - gain above gear threshold steps down power
// - below low threshold, back one gear
// - low threshold derived using shift hysteresis
// - first sample after a step down sets low threshold
// - control bit zero enables regulation
// - control bits one-three give step size
// - control bits four-seven give start gear
// - start gear loaded when field turns on
// - gear count byte, valid one to fifteen
// - power table bytes drive transmitter per gear
// - high thresholds stored per gear
// - guard time after each switch, field on
module txpg_ctrl
    import txpg_pkg::*;
#(
    parameter int unsigned GEARS          = GEAR_MAX,
    parameter int unsigned GUARD_OFS_CYCS = GUARD_OFS_CYC,
    parameter int unsigned MEAS_UNIT_CYCS = MEAS_UNIT_CYC
)
(
    input  wire logic        clk_in,
    input  wire logic        arst_n_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [7:0]  reg_rdata_out,
    input  wire logic        field_on_in,
    input  wire logic        gain_valid_in,
    input  wire logic [15:0] rx_gain_level_in,
    output logic             meas_req_out,
    output logic      [7:0]  tx_power_out,
    output logic      [3:0]  active_gear_out
);

    generate
        if (GEARS < 1 || GEARS > GEAR_MAX || MEAS_UNIT_CYCS < 1 || GUARD_OFS_CYCS < 1)
        begin : g_bad_param
            $error("txpg_ctrl: unsupported parameter value");
        end
    endgenerate

    logic [7:0]  control_reg;
    logic [7:0]  count_reg;
    logic [3:0]  shift_reg;
    logic [15:0] guard_reg;
    logic [15:0] interval_reg;
    logic [15:0] thr_mem [GEARS];
    logic [7:0]  pwr_mem [GEARS];
    logic [7:0]  rdata_reg;
    txpg_state_t state_reg;
    logic [3:0]  gear_reg;
    logic [15:0] low_thr_reg;
    logic        first_reg;
    logic        field_reg;
    logic [23:0] timer_reg;
    logic        req_reg;
    logic [7:0]  power_reg;

    // zero gears would leave no entry to drive; it acts as one
    function automatic logic [3:0] last_gear(input logic [7:0] cnt);
        logic [3:0] r;
        r = 4'h0;
        if (cnt > 8'(GEARS))
            r = 4'(GEARS - 1);
        else if (cnt != 8'h00)
            r = 4'(cnt - 8'h01);
        return r;
    endfunction

    function automatic logic [3:0] clamp_gear(input logic [4:0] g, input logic [3:0] top);
        return (g > {1'b0, top}) ? top : g[3:0];
    endfunction

    // byte address to table slot; thresholds take two bytes each
    function automatic logic [4:0] thr_slot(input logic [7:0] a);
        return 5'(a - ADDR_THR_FIRST);
    endfunction

    logic [3:0]  top_gear;
    logic [2:0]  step;
    logic [3:0]  start_gear;
    logic        enabled;
    logic        field_rise;
    logic        is_thr;
    logic        is_pwr;
    logic [4:0]  slot;
    logic [15:0] cur_thr;
    logic [15:0] low_calc;
    logic [23:0] guard_load;
    logic [23:0] interval_load;

    assign top_gear   = last_gear(count_reg);
    assign step       = (control_reg[CTL_STEP_LSB +: 3] == 3'h0) ? 3'h1
                                                                  : control_reg[CTL_STEP_LSB +: 3];
    assign start_gear = clamp_gear({1'b0, control_reg[CTL_START_LSB +: 4]}, top_gear);
    assign enabled    = control_reg[CTL_ENABLE_BIT];
    assign field_rise = field_on_in && !field_reg;
    assign slot       = thr_slot(reg_addr_in);
    assign is_thr     = (reg_addr_in >= ADDR_THR_FIRST) && (reg_addr_in <= ADDR_THR_LAST)
                        && (slot[4:1] < 4'(GEARS));
    assign is_pwr     = (reg_addr_in >= ADDR_PWR_FIRST) && (reg_addr_in <= ADDR_PWR_LAST)
                        && (4'(reg_addr_in - ADDR_PWR_FIRST) < 4'(GEARS));
    assign cur_thr    = thr_mem[gear_reg];
    assign low_calc   = rx_gain_level_in - (rx_gain_level_in >> shift_reg);
    assign guard_load = 24'(guard_reg) * 24'(GUARD_TICK_CYC) + 24'(GUARD_OFS_CYCS);
    assign interval_load = (interval_reg == 16'h0000) ? 24'h000001
                         : 24'(interval_reg) * 24'(MEAS_UNIT_CYCS);

    // configuration bytes
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            control_reg  <= RST_CONTROL;
            count_reg    <= RST_GEAR_COUNT;
            shift_reg    <= RST_SHIFT;
            guard_reg    <= RST_GUARD;
            interval_reg <= RST_INTERVAL;
        end
        else if (reg_wr_in)
        begin
            case (reg_addr_in)
                ADDR_CONTROL:    control_reg  <= reg_wdata_in;
                ADDR_GEAR_COUNT: count_reg    <= reg_wdata_in;
                ADDR_SHIFT:      shift_reg    <= reg_wdata_in[3:0];
                ADDR_GUARD_L:    guard_reg[7:0]     <= reg_wdata_in;
                ADDR_GUARD_H:    guard_reg[15:8]    <= reg_wdata_in;
                ADDR_INTERVAL_L: interval_reg[7:0]  <= reg_wdata_in;
                ADDR_INTERVAL_H: interval_reg[15:8] <= reg_wdata_in;
                default:         ;
            endcase
        end
    end

    // per-gear tables; low byte at the even slot
    for (genvar g = 0; g < GEARS; g++)
    begin : g_table
        always_ff @(posedge clk_in or negedge arst_n_in)
        begin
            if (!arst_n_in)
            begin
                thr_mem[g] <= RST_THRESHOLD;
                pwr_mem[g] <= RST_POWER;
            end
            else if (reg_wr_in)
            begin
                if (is_thr && thr_slot(reg_addr_in) == 5'(2 * g))
                    thr_mem[g][7:0] <= reg_wdata_in;
                if (is_thr && thr_slot(reg_addr_in) == 5'(2 * g + 1))
                    thr_mem[g][15:8] <= reg_wdata_in;
                if (is_pwr && 4'(reg_addr_in - ADDR_PWR_FIRST) == 4'(g))
                    pwr_mem[g] <= reg_wdata_in;
            end
        end
    end

    // read data stands one cycle late and only while the read strobe is held; unmapped bytes read zero
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            rdata_reg <= 8'h00;
        else if (!reg_rd_in)
            rdata_reg <= 8'h00;
        else if (is_thr)
            rdata_reg <= slot[0] ? thr_mem[slot[4:1]][15:8] : thr_mem[slot[4:1]][7:0];
        else if (is_pwr)
            rdata_reg <= pwr_mem[4'(reg_addr_in - ADDR_PWR_FIRST)];
        else
        begin
            case (reg_addr_in)
                ADDR_CONTROL:    rdata_reg <= control_reg;
                ADDR_GEAR_COUNT: rdata_reg <= count_reg;
                ADDR_SHIFT:      rdata_reg <= {4'h0, shift_reg};
                ADDR_GUARD_L:    rdata_reg <= guard_reg[7:0];
                ADDR_GUARD_H:    rdata_reg <= guard_reg[15:8];
                ADDR_INTERVAL_L: rdata_reg <= interval_reg[7:0];
                ADDR_INTERVAL_H: rdata_reg <= interval_reg[15:8];
                ADDR_STATUS:     rdata_reg <= {gear_reg, first_reg, field_reg, 2'(state_reg)};
                ADDR_LOW_THR_L:  rdata_reg <= low_thr_reg[7:0];
                ADDR_LOW_THR_H:  rdata_reg <= low_thr_reg[15:8];
                default:         rdata_reg <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            field_reg <= 1'b0;
        else
            field_reg <= field_on_in;
    end

    // regulation sequencer: guard or wait interval, then measure, decide
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_reg   <= TXPG_OFF;
            gear_reg    <= 4'h0;
            low_thr_reg <= 16'h0000;
            first_reg   <= 1'b0;
            timer_reg   <= 24'h000000;
            req_reg     <= 1'b0;
        end
        else
        begin
            req_reg <= 1'b0;
            if (gear_reg > top_gear)
                gear_reg <= top_gear;
            if (!field_on_in)
                state_reg <= TXPG_OFF;
            else if (field_rise)
            begin
                gear_reg    <= start_gear;
                low_thr_reg <= 16'h0000;
                first_reg   <= 1'b0;
                timer_reg   <= guard_load;
                state_reg   <= TXPG_GUARD;
            end
            else if (!enabled)
                state_reg <= TXPG_OFF;
            else
            begin
                case (state_reg)
                    TXPG_OFF:
                    begin
                        timer_reg <= interval_load;
                        state_reg <= TXPG_INTERVAL;
                    end
                    TXPG_GUARD, TXPG_INTERVAL:
                    begin
                        if (timer_reg <= 24'h000001)
                        begin
                            req_reg   <= 1'b1;
                            state_reg <= TXPG_MEASURE;
                        end
                        else
                            timer_reg <= timer_reg - 24'h000001;
                    end
                    TXPG_MEASURE:
                    begin
                        if (gain_valid_in)
                        begin
                            if (rx_gain_level_in > cur_thr && gear_reg < top_gear)
                            begin
                                gear_reg  <= clamp_gear(5'(gear_reg) + 5'(step), top_gear);
                                first_reg <= 1'b1;
                                timer_reg <= guard_load;
                                state_reg <= TXPG_GUARD;
                            end
                            else if (first_reg)
                            begin
                                low_thr_reg <= low_calc;
                                first_reg   <= 1'b0;
                                timer_reg   <= interval_load;
                                state_reg   <= TXPG_INTERVAL;
                            end
                            else if (rx_gain_level_in < low_thr_reg && gear_reg != 4'h0)
                            begin
                                gear_reg  <= gear_reg - 4'h1;
                                timer_reg <= guard_load;
                                state_reg <= TXPG_GUARD;
                            end
                            else
                            begin
                                timer_reg <= interval_load;
                                state_reg <= TXPG_INTERVAL;
                            end
                        end
                    end
                    default:
                        state_reg <= TXPG_OFF;
                endcase
            end
        end
    end

    // low gear index means high power: the table byte is simply forwarded
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            power_reg <= RST_POWER;
        else
            power_reg <= pwr_mem[gear_reg];
    end

    assign reg_rdata_out   = rdata_reg;
    assign meas_req_out    = req_reg;
    assign tx_power_out    = power_reg;
    assign active_gear_out = gear_reg;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    sequence s_enter_guard;
        (state_reg != TXPG_GUARD) ##1 (state_reg == TXPG_GUARD);
    endsequence
    sequence s_step_down_cause;
        field_on_in && !field_rise && enabled && state_reg == TXPG_MEASURE && gain_valid_in
        && rx_gain_level_in > cur_thr && gear_reg < top_gear;
    endsequence

    property p_gear_range;
        (gear_reg <= top_gear) or $changed(count_reg);
    endproperty
    a_gear_range: assert property (p_gear_range) else $error("gear beyond count");

    property p_step_down;
        s_step_down_cause |=> (gear_reg > $past(gear_reg)) && first_reg && state_reg == TXPG_GUARD;
    endproperty
    a_step_down: assert property (p_step_down) else $error("no step down");

    property p_step_up_one;
        // a rewritten gear count may clamp the gear down by more than one
        (state_reg == TXPG_MEASURE && field_on_in && !field_rise && $stable(count_reg))
        ##1 (gear_reg < $past(gear_reg))
        |-> gear_reg == $past(gear_reg) - 4'h1;
    endproperty
    a_step_up_one: assert property (p_step_up_one) else $error("up step not one");

    property p_field_load;
        field_rise |=> gear_reg == $past(start_gear) && state_reg == TXPG_GUARD;
    endproperty
    a_field_load: assert property (p_field_load) else $error("start gear not loaded");

    property p_power_follow;
        ##1 tx_power_out == $past(pwr_mem[gear_reg]);
    endproperty
    a_power_follow: assert property (p_power_follow) else $error("power byte mismatch");

    property p_low_thr;
        (field_on_in && !field_rise && enabled && state_reg == TXPG_MEASURE && gain_valid_in
         && first_reg && !(rx_gain_level_in > cur_thr && gear_reg < top_gear))
        |=> low_thr_reg == $past(rx_gain_level_in) - ($past(rx_gain_level_in) >> $past(shift_reg));
    endproperty
    a_low_thr: assert property (p_low_thr) else $error("low threshold wrong");

    property p_disabled_hold;
        (!enabled && !field_rise && gear_reg <= top_gear && !reg_wr_in) |=> $stable(gear_reg);
    endproperty
    a_disabled_hold: assert property (p_disabled_hold) else $error("gear moved while off");

    property p_guard_load;
        s_enter_guard |-> timer_reg == $past(guard_load);
    endproperty
    a_guard_load: assert property (p_guard_load) else $error("guard time wrong");

    property p_req_cause;
        meas_req_out |-> $past(state_reg == TXPG_GUARD || state_reg == TXPG_INTERVAL)
                         && state_reg == TXPG_MEASURE;
    endproperty
    a_req_cause: assert property (p_req_cause) else $error("stray measure request");

endmodule

// [tb/txpg_meas_model.sv]
// txpg_meas_model: receiver level measurement stand-in for the gear regulator
// assumes one-cycle requests on the bench clock; answers delay_in + 1 cycles after a request
`timescale 1ns/1ps
module txpg_meas_model
(
    input  wire logic        clk_in,
    input  wire logic        meas_req_in,
    input  wire logic [15:0] level_in,
    input  wire logic [3:0]  delay_in,
    output logic             gain_valid_out,
    output logic      [15:0] rx_gain_level_out
);
    logic [3:0] cnt_reg;
    logic       busy_reg;

    initial
    begin
        gain_valid_out = 1'b0;
        rx_gain_level_out = 16'h0000;
        cnt_reg = 4'h0;
        busy_reg = 1'b0;
    end

    always @(posedge clk_in)
    begin
        if (!meas_req_in && busy_reg && cnt_reg == 4'h0)
        begin
            gain_valid_out <= 1'b1;
            rx_gain_level_out <= level_in;
            busy_reg <= 1'b0;
        end
        else
        begin
            gain_valid_out <= 1'b0;
            // level is not held outside the valid cycle
            rx_gain_level_out <= ~rx_gain_level_out;
            if (meas_req_in)
            begin
                busy_reg <= 1'b1;
                cnt_reg <= delay_in;
            end
            else if (busy_reg)
                cnt_reg <= cnt_reg - 4'h1;
        end
    end
endmodule

// [tb/txpg_ctrl_tb.sv]
// txpg_ctrl_tb: self-checking bench for the transmit power gear regulator
// assumes shortened guard offset and measure unit; measurement model on the far side
`timescale 1ns/1ps
module txpg_ctrl_tb
    import txpg_pkg::*;
;
    localparam int OFS = 5;
    logic        clk;
    logic        arst_n;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        wr;
    logic        rd;
    logic        field_on;
    logic        gvalid;
    logic        mreq;
    logic [15:0] glevel;
    logic [15:0] level;
    logic [7:0]  txp;
    logic [3:0]  gear;
    logic [3:0]  dly;
    logic [7:0]  ptab [0:14];
    int          err_total;
    int          checked;
    int          seed;
    int          n;
    int          n1;

    txpg_ctrl #(.GEARS(15), .GUARD_OFS_CYCS(OFS), .MEAS_UNIT_CYCS(2)) u_dut (
        .clk_in(clk), .arst_n_in(arst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .field_on_in(field_on),
        .gain_valid_in(gvalid), .rx_gain_level_in(glevel), .meas_req_out(mreq),
        .tx_power_out(txp), .active_gear_out(gear));

    txpg_meas_model u_meas (
        .clk_in(clk), .meas_req_in(mreq), .level_in(level), .delay_in(dly),
        .gain_valid_out(gvalid), .rx_gain_level_out(glevel));

    always #2.5 clk = ~clk;

    function automatic logic [15:0] low_thr(input logic [15:0] g, input logic [3:0] s);
        return g - (g >> s);
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic check_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check("register", {8'h00, rdata}, {8'h00, exp});
    endtask

    task automatic wait_gear(input logic [3:0] g);
        int k;
        k = 0;
        while (gear !== g && k < 3000)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k >= 3000)
        begin
            err_total++;
            summarize();
        end
        @(posedge clk);
        #1;
        check("tx power", {8'h00, txp}, {8'h00, ptab[g]});
    endtask

    // cycles until the next request pulse
    task automatic to_req(output int c);
        c = 0;
        do
        begin
            @(posedge clk);
            #1;
            c++;
        end while (mreq !== 1'b1 && c < 30000);
        if (c >= 30000)
        begin
            err_total++;
            summarize();
        end
    endtask

    task automatic hold_gear(input logic [3:0] g);
        repeat (150) @(posedge clk);
        #1;
        check("gear", {12'h000, gear}, {12'h000, g});
    endtask

    initial
    begin
        clk = 1'b0;
        seed = 32'hc455;
        {arst_n, wr, rd, field_on} = 4'h0;
        {addr, wdata, level, dly} = '0;
        {err_total, checked} = 0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        check_rd(ADDR_CONTROL, RST_CONTROL);
        check_rd(ADDR_GEAR_COUNT, RST_GEAR_COUNT);
        check_rd(ADDR_SHIFT, {4'h0, RST_SHIFT});
        check_rd(ADDR_GUARD_H, RST_GUARD[15:8]);
        check_rd(ADDR_INTERVAL_L, RST_INTERVAL[7:0]);
        check_rd(ADDR_THR_LAST, RST_THRESHOLD[15:8]);
        check_rd(ADDR_PWR_LAST, RST_POWER);
        check_rd(8'h00, 8'h00);
        $display("test reset values done");
        for (int g = 0; g < 15; g++)
        begin
            ptab[g] = 8'($random(seed));
            wr_reg(ADDR_PWR_FIRST + 8'(g), ptab[g]);
            n1 = $random(seed);
            n = (g < 5) ? 32'h1000 : {16'h0, n1[7:0], ~n1[7:0]};
            wr_reg(ADDR_THR_FIRST + 8'(2 * g), 8'(n));
            wr_reg(ADDR_THR_FIRST + 8'(2 * g + 1), 8'(n >> 8));
            check_rd(ADDR_PWR_FIRST + 8'(g), ptab[g]);
            check_rd(ADDR_THR_FIRST + 8'(2 * g + 1), 8'(n >> 8));
        end
        $display("test tables done");
        wr_reg(ADDR_GEAR_COUNT, 8'h05);
        wr_reg(ADDR_SHIFT, 8'h02);
        wr_reg(ADDR_GUARD_L, 8'h03);
        wr_reg(ADDR_GUARD_H, 8'h00);
        wr_reg(ADDR_INTERVAL_L, 8'h0A);
        level <= 16'h0800;
        @(posedge clk);
        field_on <= 1'b1;
        to_req(n);
        check("guard window", 16'(n >= 3 * 10 + OFS - 2 && n <= 3 * 10 + OFS + 4), 16'h1);
        to_req(n1);
        wr_reg(ADDR_INTERVAL_L, 8'h14);
        to_req(n);
        to_req(n);
        check("interval delta", 16'(n - n1), 16'd20);
        wr_reg(ADDR_LOW_THR_L, 8'hFF);
        check_rd(ADDR_LOW_THR_L, 8'h00);
        $display("test guard and interval done");
        dly <= 4'($random(seed) & 3);
        level <= 16'h2000;
        for (int g = 1; g < 5; g++)
            wait_gear(4'(g));
        hold_gear(4'h4);
        check_rd(ADDR_LOW_THR_H, 8'(low_thr(16'h2000, 4'h2) >> 8));
        check_rd(ADDR_LOW_THR_L, 8'(low_thr(16'h2000, 4'h2)));
        $display("test step down done");
        level <= 16'h0800 + 16'($random(seed) & 16'h07FF);
        for (int g = 3; g >= 0; g--)
            wait_gear(4'(g));
        level <= 16'h1000;
        hold_gear(4'h0);
        $display("test step up done");
        wr_reg(ADDR_CONTROL, 8'h07);
        level <= 16'h2000;
        wait_gear(4'h3);
        wait_gear(4'h4);
        wr_reg(ADDR_GEAR_COUNT, 8'h02);
        wait_gear(4'h1);
        $display("test step size done");
        field_on <= 1'b0;
        wr_reg(ADDR_GEAR_COUNT, 8'h05);
        wr_reg(ADDR_CONTROL, 8'h23);
        level <= 16'h0800;
        field_on <= 1'b1;
        wait_gear(4'h2);
        hold_gear(4'h2);
        field_on <= 1'b0;
        // a new start gear, so the reload is visible while regulation is off
        wr_reg(ADDR_CONTROL, 8'h32);
        level <= 16'h2000;
        field_on <= 1'b1;
        wait_gear(4'h3);
        n = 0;
        repeat (300)
        begin
            @(posedge clk);
            #1;
            if (mreq === 1'b1)
                n++;
        end
        check("requests", 16'(n), 16'h0000);
        hold_gear(4'h3);
        $display("test start gear and disable done");
        summarize();
    end
endmodule
